// file: dwsc_regs.svh
`ifndef DWSC_REGS_SVH
`define DWSC_REGS_SVH

// frame layout, most significant bit first on the wire
`define DWSC_FRAME_BITS 24
`define DWSC_CMD_MSB 23
`define DWSC_CMD_LSB 20
`define DWSC_ADDR_MSB 19
`define DWSC_ADDR_LSB 16
`define DWSC_DATA_MSB 15
`define DWSC_WIPER_MSB 9

// wiper and storage values
`define DWSC_WIPER_ZERO 10'h000
`define DWSC_WIPER_MID 10'h200
`define DWSC_WIPER_FULL 10'h3FF
`define DWSC_USER_RESET 16'h0000
`define DWSC_NV_WORDS 16
`define DWSC_USER_FIRST 4'h2
`define DWSC_USER_LAST 4'hE

// timing
`define DWSC_SYS_CLK_HZ 40000000
`define DWSC_STORE_MS 15
`define DWSC_STORE_CYC (`DWSC_STORE_MS * (`DWSC_SYS_CLK_HZ / 1000))
`define DWSC_RDY_PULSE_NS 100
`define DWSC_RDY_PULSE_CYC ((`DWSC_RDY_PULSE_NS * (`DWSC_SYS_CLK_HZ / 1000000) + 999) / 1000)

`endif

// file: dwsc_pkg.sv
package dwsc_pkg;

    // command codes carried in the top nibble of a frame
    typedef enum logic [3:0] {
        DWSC_CMD_NOP = 4'h0,
        DWSC_CMD_RESTORE_ONE = 4'h1,
        DWSC_CMD_STORE_WIPER = 4'h2,
        DWSC_CMD_STORE_ANY = 4'h3,
        DWSC_CMD_HALVE_ONE = 4'h4,
        DWSC_CMD_HALVE_ALL = 4'h5,
        DWSC_CMD_DEC_ONE = 4'h6,
        DWSC_CMD_DEC_ALL = 4'h7,
        DWSC_CMD_RESTORE_ALL = 4'h8,
        DWSC_CMD_READ_NV = 4'h9,
        DWSC_CMD_READ_WIPER = 4'hA,
        DWSC_CMD_WRITE_WIPER = 4'hB,
        DWSC_CMD_DOUBLE_ONE = 4'hC,
        DWSC_CMD_DOUBLE_ALL = 4'hD,
        DWSC_CMD_INC_ONE = 4'hE,
        DWSC_CMD_INC_ALL = 4'hF
    } dwsc_cmd_t;

    typedef enum logic [1:0] {
        DWSC_OP_HALVE,
        DWSC_OP_DEC,
        DWSC_OP_DOUBLE,
        DWSC_OP_INC
    } dwsc_op_t;

    typedef enum {
        DWSC_ST_IDLE,
        DWSC_ST_STORE,
        DWSC_ST_PULSE,
        DWSC_ST_PRESET
    } dwsc_state_t;

endpackage : dwsc_pkg

// file: dwsc_link_if.sv
// words passed between the serial-clock front end and the system-clock core
interface dwsc_link_if;
    logic rst;
    logic [23:0] frame;
    logic [7:0] cnt_gray;
    logic out_bit;
    logic rb_mode;
    logic [23:0] rb_word;
    logic [7:0] frame_start;

    modport link (input rst, output frame, output cnt_gray, output out_bit,
        input rb_mode, input rb_word, input frame_start);
    modport core (output rst, input frame, input cnt_gray, input out_bit,
        output rb_mode, output rb_word, output frame_start);
endinterface : dwsc_link_if

// file: dwsc_link.sv
`include "dwsc_regs.svh"

// serial front end; runs only on the host's serial clock edges
module dwsc_link import dwsc_pkg::*; (
    input wire logic serial_clk,
    input wire logic cs_n,
    input wire logic sdi,
    dwsc_link_if.link lnk
);

    logic [23:0] shreg_r;
    logic [7:0] cnt_r;
    logic [7:0] cnt_gray_r;
    logic [7:0] cnt_inc;
    logic [7:0] bit_idx;
    logic rb_sel;
    logic [4:0] rb_pos;

    assign cnt_inc = cnt_r + 8'h01;

    // one bit per rising edge, msb arrives first; gray copy crosses to the core
    always_ff @(posedge serial_clk or posedge lnk.rst) begin
        if (lnk.rst) begin
            shreg_r <= 24'h000000;
            cnt_r <= 8'h00;
            cnt_gray_r <= 8'h00;
        end else if (!cs_n) begin
            shreg_r <= {shreg_r[22:0], sdi};
            cnt_r <= cnt_inc;
            cnt_gray_r <= cnt_inc ^ {1'b0, cnt_inc[7:1]};
        end
    end

    // readback word for the first 24 bits, otherwise the delayed frame
    assign bit_idx = cnt_r - lnk.frame_start;
    assign rb_sel = lnk.rb_mode && (bit_idx < 8'h18);
    assign rb_pos = 5'h17 - bit_idx[4:0];
    assign lnk.out_bit = rb_sel ? lnk.rb_word[rb_pos] : shreg_r[23];
    assign lnk.frame = shreg_r;
    assign lnk.cnt_gray = cnt_gray_r;

endmodule : dwsc_link

// file: dwsc_core.sv
`include "dwsc_regs.svh"

module dwsc_core import dwsc_pkg::*; #(
    parameter int STORE_CYC = `DWSC_STORE_CYC
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic serial_clk,
    input wire logic cs_n,
    input wire logic sdi,
    input wire logic preset_strobe_n,
    input wire logic write_protect_n,
    output logic sdo_o,
    output logic sdo_oe,
    output logic ready_o,
    output logic ready_oe,
    output logic [9:0] wiper_scratchpad_ch1,
    output logic [9:0] wiper_scratchpad_ch2
);

    localparam int PULSE_CYC = (`DWSC_RDY_PULSE_CYC < 1) ? 1 : `DWSC_RDY_PULSE_CYC;
    localparam logic [19:0] STORE_LAST = 20'(STORE_CYC - 1);
    localparam logic [19:0] PULSE_LAST = 20'(PULSE_CYC - 1);

    dwsc_link_if lnk ();

    // serial front end on its own clock
    dwsc_link u_link (
        .serial_clk (serial_clk),
        .cs_n (cs_n),
        .sdi (sdi),
        .lnk (lnk)
    );

    // ---- crossings -------------------------------------------------------
    // bit order: gray count, serial out bit, write protect, preset, chip select
    logic [11:0] meta_r;
    logic [11:0] sync_r;
    logic [11:0] async_in;
    logic cs_s;
    logic preset_s;
    logic wp_s;
    logic out_bit_s;
    logic [7:0] gray_s;

    assign async_in = {lnk.cnt_gray, lnk.out_bit, write_protect_n, preset_strobe_n, cs_n};

    // two flops on every control level from a pin or the serial clock; the frame word is used without them
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            meta_r <= 12'h007;
            sync_r <= 12'h007;
        end else begin
            meta_r <= async_in;
            sync_r <= meta_r;
        end
    end

    assign cs_s = sync_r[0];
    assign preset_s = sync_r[1];
    assign wp_s = sync_r[2];
    assign out_bit_s = sync_r[3];
    assign gray_s = sync_r[11:4];

    // gray back to binary for the bit count
    function automatic logic [7:0] gray_to_bin(input logic [7:0] g);
        logic [7:0] b;
        b[7] = g[7];
        for (int i = 6; i >= 0; i--) begin
            b[i] = b[i + 1] ^ g[i];
        end
        return b;
    endfunction : gray_to_bin

    // saturating single-channel arithmetic for the step and shift commands
    function automatic logic [9:0] wiper_op(input dwsc_op_t op, input logic [9:0] v);
        logic [9:0] r;
        r = v;
        unique case (op)
            DWSC_OP_HALVE: r = {1'b0, v[9:1]};
            DWSC_OP_DOUBLE: r = v[9] ? `DWSC_WIPER_FULL : {v[8:0], 1'b0};
            DWSC_OP_DEC: r = (v == `DWSC_WIPER_ZERO) ? v : v - 10'h001;
            DWSC_OP_INC: r = (v == `DWSC_WIPER_FULL) ? v : v + 10'h001;
        endcase
        return r;
    endfunction : wiper_op

    // ---- frame framing ---------------------------------------------------
    logic cs_prev_r;
    logic [7:0] frame_start_r;
    logic [7:0] cnt_bin;
    logic [7:0] bits_in_frame;
    logic cs_rise;
    logic frame_ok;

    assign cnt_bin = gray_to_bin(gray_s);
    assign bits_in_frame = cnt_bin - frame_start_r;
    assign cs_rise = cs_s && !cs_prev_r;
    // a count of zero repeats the previous frame, which stays in the shift register
    assign frame_ok = (bits_in_frame[1:0] == 2'b00);

    // the shift register is idle while chip select is high, so its word is steady here
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            cs_prev_r <= 1'b1;
            frame_start_r <= 8'h00;
        end else begin
            cs_prev_r <= cs_s;
            if (cs_rise) begin
                frame_start_r <= cnt_bin;
            end
        end
    end

    // ---- field decode ----------------------------------------------------
    dwsc_cmd_t cmd;
    logic [3:0] addr;
    logic [15:0] data;
    logic [9:0] data_wiper;
    logic ch;
    logic is_user_addr;
    logic is_step;
    logic step_all;
    dwsc_op_t step_op;

    assign cmd = dwsc_cmd_t'(lnk.frame[`DWSC_CMD_MSB:`DWSC_CMD_LSB]);
    assign addr = lnk.frame[`DWSC_ADDR_MSB:`DWSC_ADDR_LSB];
    assign data = lnk.frame[`DWSC_DATA_MSB:0];
    assign data_wiper = data[`DWSC_WIPER_MSB:0];
    assign ch = addr[0];
    assign is_user_addr = (addr >= `DWSC_USER_FIRST) && (addr <= `DWSC_USER_LAST);
    assign is_step = lnk.frame[`DWSC_CMD_LSB + 2];
    assign step_all = lnk.frame[`DWSC_CMD_LSB];
    assign step_op = dwsc_op_t'({lnk.frame[`DWSC_CMD_MSB], lnk.frame[`DWSC_CMD_LSB + 1]});

    // ---- state -----------------------------------------------------------
    dwsc_state_t state_r;
    dwsc_state_t state_nxt;
    logic [19:0] busy_cnt_r;
    logic [19:0] busy_cnt_nxt;
    logic [1:0][9:0] wiper_r;
    logic [1:0][9:0] wiper_nxt;
    logic [15:0] nv_r [`DWSC_NV_WORDS];
    logic nv_we;
    logic [3:0] nv_waddr;
    logic [15:0] nv_wdata;
    logic rb_mode_r;
    logic rb_mode_nxt;
    logic [23:0] rb_word_r;
    logic [23:0] rb_word_nxt;
    logic exec;
    logic wp_ok;
    logic [15:0] nv_rdata;

    // a frame in a busy window is dropped; the shift register still fills
    assign exec = cs_rise && frame_ok && (state_r == DWSC_ST_IDLE) && preset_s;
    assign wp_ok = wp_s;
    assign nv_rdata = nv_r[addr];

    // command execution, preset override and ready timing
    always_comb begin
        state_nxt = state_r;
        busy_cnt_nxt = busy_cnt_r;
        wiper_nxt = wiper_r;
        nv_we = 1'b0;
        nv_waddr = addr;
        nv_wdata = data;
        rb_mode_nxt = rb_mode_r;
        rb_word_nxt = rb_word_r;
        if (!preset_s) begin
            wiper_nxt[0] = `DWSC_WIPER_MID;
            wiper_nxt[1] = `DWSC_WIPER_MID;
            state_nxt = DWSC_ST_PRESET;
            busy_cnt_nxt = 20'h00000;
        end else begin
            unique case (state_r)
                DWSC_ST_PRESET: begin
                    // stored values only load on the rising edge of the strobe
                    wiper_nxt[0] = nv_r[0][`DWSC_WIPER_MSB:0];
                    wiper_nxt[1] = nv_r[1][`DWSC_WIPER_MSB:0];
                    state_nxt = DWSC_ST_PULSE;
                    busy_cnt_nxt = 20'h00000;
                end
                DWSC_ST_STORE, DWSC_ST_PULSE: begin
                    if (busy_cnt_r == ((state_r == DWSC_ST_STORE) ? STORE_LAST : PULSE_LAST)) begin
                        state_nxt = DWSC_ST_IDLE;
                    end else begin
                        busy_cnt_nxt = busy_cnt_r + 20'h00001;
                    end
                end
                DWSC_ST_IDLE: begin
                    if (exec) begin
                        rb_mode_nxt = 1'b0;
                        busy_cnt_nxt = 20'h00000;
                        unique case (cmd)
                            DWSC_CMD_NOP: begin
                            end
                            DWSC_CMD_RESTORE_ONE: begin
                                wiper_nxt[ch] = nv_r[ch][`DWSC_WIPER_MSB:0];
                            end
                            DWSC_CMD_RESTORE_ALL: begin
                                wiper_nxt[0] = nv_r[0][`DWSC_WIPER_MSB:0];
                                wiper_nxt[1] = nv_r[1][`DWSC_WIPER_MSB:0];
                                state_nxt = DWSC_ST_PULSE;
                            end
                            DWSC_CMD_STORE_WIPER: begin
                                if (wp_ok) begin
                                    nv_we = 1'b1;
                                    nv_waddr = {3'b000, ch};
                                    nv_wdata = {6'h00, wiper_r[ch]};
                                    state_nxt = DWSC_ST_STORE;
                                end
                            end
                            DWSC_CMD_STORE_ANY: begin
                                if (wp_ok && (addr[3:1] == 3'b000)) begin
                                    nv_we = 1'b1;
                                    nv_waddr = {3'b000, ch};
                                    nv_wdata = {6'h00, wiper_r[ch]};
                                    state_nxt = DWSC_ST_STORE;
                                end else if (wp_ok && is_user_addr) begin
                                    nv_we = 1'b1;
                                    state_nxt = DWSC_ST_STORE;
                                end
                            end
                            DWSC_CMD_READ_NV: begin
                                rb_mode_nxt = 1'b1;
                                rb_word_nxt = {lnk.frame[23:16], nv_rdata};
                                state_nxt = DWSC_ST_PULSE;
                            end
                            DWSC_CMD_READ_WIPER: begin
                                rb_mode_nxt = 1'b1;
                                rb_word_nxt = {lnk.frame[23:16], 6'h00, wiper_r[ch]};
                                state_nxt = DWSC_ST_PULSE;
                            end
                            DWSC_CMD_WRITE_WIPER: begin
                                if (wp_ok) begin
                                    wiper_nxt[ch] = data_wiper;
                                end
                            end
                            default: begin
                                // halve, double, decrement and increment, one or both
                                if (wp_ok && is_step) begin
                                    if (step_all || !ch) begin
                                        wiper_nxt[0] = wiper_op(step_op, wiper_r[0]);
                                    end
                                    if (step_all || ch) begin
                                        wiper_nxt[1] = wiper_op(step_op, wiper_r[1]);
                                    end
                                end
                            end
                        endcase
                    end
                end
            endcase
        end
    end

    // control registers; wipers come up at the factory midscale value
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            state_r <= DWSC_ST_IDLE;
            busy_cnt_r <= 20'h00000;
            wiper_r[0] <= `DWSC_WIPER_MID;
            wiper_r[1] <= `DWSC_WIPER_MID;
            rb_mode_r <= 1'b0;
            rb_word_r <= 24'h000000;
        end else begin
            state_r <= state_nxt;
            busy_cnt_r <= busy_cnt_nxt;
            wiper_r <= wiper_nxt;
            rb_mode_r <= rb_mode_nxt;
            rb_word_r <= rb_word_nxt;
        end
    end

    // storage array; the wiper words start at midscale, user words at zero
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            for (int i = 0; i < `DWSC_NV_WORDS; i++) begin
                nv_r[i] <= (i < 2) ? {6'h00, `DWSC_WIPER_MID} : `DWSC_USER_RESET;
            end
        end else if (nv_we) begin
            nv_r[nv_waddr] <= nv_wdata;
        end
    end

    // ---- link-side handover ----------------------------------------------
    // these only change after a chip select rise; steady next frame if the host waits for ready
    logic link_rst_r;

    always_ff @(posedge sys_clk) begin
        link_rst_r <= reset;
    end

    assign lnk.rst = link_rst_r;
    assign lnk.rb_mode = rb_mode_r;
    assign lnk.rb_word = rb_word_r;
    assign lnk.frame_start = frame_start_r;

    // ---- pins ------------------------------------------------------------
    logic sdo_oe_r;
    logic ready_oe_r;
    logic [9:0] wiper_ch1_r;
    logic [9:0] wiper_ch2_r;

    // open drain: pull low only for a zero bit, and never while deselected
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            sdo_oe_r <= 1'b0;
            ready_oe_r <= 1'b0;
        end else begin
            sdo_oe_r <= !cs_s && !out_bit_s;
            ready_oe_r <= (state_nxt != DWSC_ST_IDLE);
        end
    end

    // the wiper outputs mirror the scratchpads one cycle later
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            wiper_ch1_r <= `DWSC_WIPER_MID;
            wiper_ch2_r <= `DWSC_WIPER_MID;
        end else begin
            wiper_ch1_r <= wiper_r[0];
            wiper_ch2_r <= wiper_r[1];
        end
    end

    // the driven level of both open-drain pins is always low
    logic low_r;

    always_ff @(posedge sys_clk) begin
        low_r <= 1'b0;
    end

    assign sdo_o = low_r;
    assign sdo_oe = sdo_oe_r;
    assign ready_o = low_r;
    assign ready_oe = ready_oe_r;
    assign wiper_scratchpad_ch1 = wiper_ch1_r;
    assign wiper_scratchpad_ch2 = wiper_ch2_r;

endmodule : dwsc_core

// file: dwsc_monitor.sv
module dwsc_monitor import dwsc_pkg::*; #(
    parameter int STORE_CYC = 50
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic cs_n,
    input wire logic preset_strobe_n,
    input wire logic sdo_o,
    input wire logic sdo_oe,
    input wire logic ready_o,
    input wire logic ready_oe,
    input wire logic [9:0] wiper_scratchpad_ch1,
    input wire logic [9:0] wiper_scratchpad_ch2
);
    default clocking cb @(posedge sys_clk);
    endclocking

    // busy run length, and quiet time since the last frame or preset activity
    logic [19:0] busy_r;
    logic [19:0] busy_nxt;
    logic [3:0] age_r;
    logic [3:0] age_nxt;
    assign busy_nxt = ready_oe ? busy_r + 20'h00001 : 20'h00000;
    assign age_nxt = (!cs_n || !preset_strobe_n) ? 4'h0 : age_r + {3'h0, age_r != 4'hF};

    // age saturates so a long idle spell cannot wrap into a false recent cause
    always_ff @(posedge sys_clk) begin
        busy_r <= reset ? 20'h00000 : busy_nxt;
        age_r <= reset ? 4'hF : age_nxt;
    end

    sequence s_cs_idle;
        cs_n [*6];
    endsequence
    sequence s_pr_low;
        !preset_strobe_n [*5];
    endsequence
    sequence s_quiet;
        (cs_n && preset_strobe_n) [*8];
    endsequence

    property p_reset_vals;
        reset |=> wiper_scratchpad_ch1 == 10'h200 && wiper_scratchpad_ch2 == 10'h200
            && !ready_oe && !sdo_oe;
    endproperty
    property p_sdo_release;
        disable iff (reset) s_cs_idle |-> !sdo_oe;
    endproperty
    property p_od_drive;
        disable iff (reset) ready_o == 1'b0 && sdo_o == 1'b0;
    endproperty
    property p_preset_mid;
        disable iff (reset) s_pr_low |-> wiper_scratchpad_ch1 == 10'h200
            && wiper_scratchpad_ch2 == 10'h200 && ready_oe;
    endproperty
    property p_rdy_pulse;
        disable iff (reset) $rose(ready_oe) |-> ready_oe [*4];
    endproperty
    property p_store_bound;
        disable iff (reset) ready_oe |-> int'(busy_r) <= STORE_CYC;
    endproperty
    property p_rdy_cause;
        disable iff (reset) $rose(ready_oe) |-> age_r <= 4'h8;
    endproperty
    property p_idle_stable;
        disable iff (reset) s_quiet |-> $stable(wiper_scratchpad_ch1)
            && $stable(wiper_scratchpad_ch2);
    endproperty

    a_reset_vals: assert property (p_reset_vals)
        else $error("outputs wrong after reset");
    a_sdo_release: assert property (p_sdo_release)
        else $error("serial out driven while deselected");
    a_od_drive: assert property (p_od_drive)
        else $error("open-drain drive value not low");
    a_preset_mid: assert property (p_preset_mid)
        else $error("preset low without midscale and busy");
    a_rdy_pulse: assert property (p_rdy_pulse)
        else $error("ready pulse too short");
    a_store_bound: assert property (p_store_bound)
        else $error("busy longer than a store");
    a_rdy_cause: assert property (p_rdy_cause)
        else $error("busy without frame or preset");
    a_idle_stable: assert property (p_idle_stable)
        else $error("wiper moved with no frame");
endmodule : dwsc_monitor

bind dwsc_core dwsc_monitor #(.STORE_CYC(STORE_CYC)) u_mon (.sys_clk(sys_clk), .reset(reset),
    .cs_n(cs_n), .preset_strobe_n(preset_strobe_n), .sdo_o(sdo_o), .sdo_oe(sdo_oe),
    .ready_o(ready_o), .ready_oe(ready_oe), .wiper_scratchpad_ch1(wiper_scratchpad_ch1),
    .wiper_scratchpad_ch2(wiper_scratchpad_ch2));

// file: dwsc_host.sv
// host serial master; its clock runs only inside frames
module dwsc_host (
    output logic serial_clk,
    output logic cs_n,
    output logic sdi,
    input wire logic sdo_pin
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        serial_clk = 1'b0;
        cs_n = 1'b1;
        sdi = 1'b1;
    end

    // sdo sampled just before each rise: the device resyncs it, so a bit trails its shift edge
    task automatic xfer(input logic [23:0] w, input int n, output logic [23:0] rd);
        rd = 24'h000000;
        cs_n = 1'b0;
        #60;
        for (int i = n - 1; i >= 0; i--) begin
            sdi = w[i];
            #30 rd = {rd[22:0], sdo_pin};
            serial_clk = 1'b1;
            #62.5 serial_clk = 1'b0;
            #32.5;
        end
        #60 sdi = ~sdi; // no stale level left on the data line
        cs_n = 1'b1;
    endtask : xfer
endmodule : dwsc_host

// file: tb_top.sv
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int STORE_CYC = 400;
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic preset_strobe_n = 1'b1;
    logic write_protect_n = 1'b1;
    wire serial_clk, cs_n, sdi;
    logic sdo_o, sdo_oe, ready_o, ready_oe;
    logic [9:0] w1, w2;
    wire sdo_pin = ~sdo_oe; // pull-up on the open-drain line
    logic [23:0] rd;
    int error_cnt = 0;
    int total_checks = 0;

    always #12.5 sys_clk = ~sys_clk;

    dwsc_host host (.serial_clk(serial_clk), .cs_n(cs_n), .sdi(sdi), .sdo_pin(sdo_pin));
    dwsc_core #(.STORE_CYC(STORE_CYC)) dut (.sys_clk(sys_clk), .reset(reset),
        .serial_clk(serial_clk), .cs_n(cs_n), .sdi(sdi), .preset_strobe_n(preset_strobe_n),
        .write_protect_n(write_protect_n), .sdo_o(sdo_o), .sdo_oe(sdo_oe), .ready_o(ready_o),
        .ready_oe(ready_oe), .wiper_scratchpad_ch1(w1), .wiper_scratchpad_ch2(w2));

    task automatic wrap_up();
        $display("errors %0d checks %0d", error_cnt, total_checks);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : wrap_up

    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // both wipers packed into one compare
    task automatic wchk(input logic [9:0] e1, input logic [9:0] e2);
        chk({4'h0, w1, w2}, {4'h0, e1, e2});
    endtask : wchk

    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask : cyc

    // gap after each frame covers chip-select sync and the wiper port delay
    task automatic frame(input logic [23:0] w);
        host.xfer(w, 24, rd);
        cyc(10);
    endtask : frame

    task automatic wait_idle();
        int n;
        n = 0;
        while (ready_oe !== 1'b0 && n < 1000) begin
            cyc(1);
            n++;
        end
        if (n >= 1000) begin
            error_cnt++;
            $display("FAIL t=%0t busy=%h exp=%h", $time, ready_oe, 1'b0);
            wrap_up();
        end
    endtask : wait_idle

    function automatic logic [9:0] step_exp(input logic [3:0] c, input logic [9:0] v);
        case (c[3:1])
            3'h2: return v >> 1;
            3'h3: return (v == 10'h000) ? v : v - 10'h001;
            3'h6: return v[9] ? 10'h3FF : v << 1;
            default: return (v == 10'h3FF) ? v : v + 10'h001;
        endcase
    endfunction : step_exp

    initial begin
        realtime t0;
        int e;
        logic [3:0] c;
        cyc(4);
        reset <= 1'b0;
        cyc(4);
        wchk(10'h200, 10'h200);
        frame(24'hB00100);
        wchk(10'h100, 10'h200);
        frame(24'hB1FD55);
        wchk(10'h100, 10'h155);
        frame(24'hA00000);
        frame(24'hE00000);
        chk(rd, 24'hA00100);
        frame(24'h000000);
        chk(rd, 24'hE00000);
        wchk(10'h101, 10'h155);
        // store, with a frame sent while it runs
        host.xfer(24'h200000, 24, rd);
        t0 = $realtime;
        cyc(10);
        frame(24'hB003FF);
        chk({23'h000000, ready_oe}, 24'h000001);
        wait_idle();
        e = int'(($realtime - t0) / 25.0);
        chk({23'h000000, e >= STORE_CYC && e <= STORE_CYC + 8}, 24'h000001);
        wchk(10'h101, 10'h155);
        frame(24'hB00222);
        frame(24'h100000);
        wchk(10'h101, 10'h155);
        frame(24'h800000);
        wait_idle();
        wchk(10'h101, 10'h200);
        for (int i = 0; i < 8; i++) begin
            c = {i[2], 1'b1, i[1:0]};
            frame(24'hB00001);
            frame(24'hB103FF);
            frame({c, 4'h1, 16'h0000});
            wchk(c[0] ? step_exp(c, 10'h001) : 10'h001, step_exp(c, 10'h3FF));
        end
        write_protect_n <= 1'b0;
        cyc(4);
        frame(24'hB00050);
        wchk(10'h002, 10'h3FF);
        frame(24'h100000);
        wchk(10'h101, 10'h3FF);
        write_protect_n <= 1'b1;
        cyc(4);
        host.xfer(24'h0B0077, 23, rd);
        cyc(10);
        wchk(10'h101, 10'h3FF);
        frame(24'hB10123);
        wchk(10'h101, 10'h123);
        frame(24'h35BEEF);
        wait_idle();
        frame(24'h950000);
        wait_idle();
        frame(24'h000000);
        chk(rd, 24'h95BEEF);
        preset_strobe_n <= 1'b0;
        cyc(8);
        wchk(10'h200, 10'h200);
        chk({23'h000000, ready_oe}, 24'h000001);
        preset_strobe_n <= 1'b1;
        cyc(2);
        wait_idle();
        wchk(10'h101, 10'h200);
        wrap_up();
    end
endmodule : tb_top
